// ---- common/cmp_ctrl_map.vh ----
// Register offsets, field positions, reset values and timing for the comparator control block
`ifndef CMP_CTRL_MAP_VH
`define CMP_CTRL_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CMP1_CTRL_OFS 12'h000
`define CMP2_CTRL_OFS 12'h004
`define SHARED_CTRL_OFS 12'h008
`define FLAG_OFS 12'h00C
`define IRQ_EN_OFS 12'h010
`define PIN_CFG_OFS 12'h014

// ----------------------------------------
// Per-comparator control fields
// ----------------------------------------
`define CTL_ENABLE 7
`define CTL_RESULT 6
`define CTL_PIN_DRIVE 5
`define CTL_INVERT 4
`define CTL_SPEED 3
`define CTL_REF_SEL 2
`define CTL_CH_HI 1
`define CTL_CH_LO 0
`define CTL_RESET 8'h08

// ----------------------------------------
// Shared control fields
// ----------------------------------------
`define SH_MIRROR1 7
`define SH_MIRROR2 6
`define SH_VSRC1 5
`define SH_VSRC2 4
`define SH_RESET 8'h00

// ----------------------------------------
// Irq enable fields
// ----------------------------------------
`define IE_CMP1 0
`define IE_CMP2 1
`define IE_PERIPH 2
`define IE_GLOBAL 3

// ----------------------------------------
// Instruction cycle phases
// ----------------------------------------
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

`endif

// ---- hw/cmp_ctrl.v ----
// Two-comparator control, mismatch and interrupt-flag logic with an APB slave
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "cmp_ctrl_map.vh"

module cmp_ctrl (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [1:0] raw_compare,
	input wire [1:0] port_latch,
	output reg [1:0] cmp_pin_out,
	output reg [1:0] cmp_pin_oe,
	output reg [1:0] cmp_power_on,
	output reg [1:0] cmp_fast_mode,
	output reg [3:0] neg_input_select,
	output reg [1:0] pos_ref_select,
	output reg [1:0] vref_source_select,
	output reg [1:0] cmp_irq_flag,
	output reg irq_request,
	output reg wake_request
);

	// ----------------------------------------
	// Phase counter and strobes
	// ----------------------------------------
	reg [1:0] phase_q;
	wire q1 = (phase_q == `PH_Q1);
	wire q3 = (phase_q == `PH_Q3);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 2'h0;
		end else if (clk_en) begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] ctl1_q;
	reg [7:0] ctl2_q;
	reg [7:0] shared_q;
	reg [3:0] irq_en_q;
	reg [1:0] pin_dir_q;
	reg [1:0] sync_q;
	reg [1:0] first_q;
	reg [1:0] second_q;
	reg [1:0] mis_prev_q;

	// Result bit: disabled comparator shows its invert bit
	function result_of;
		input [7:0] ctl;
		input raw;
		begin
			if (!ctl[`CTL_ENABLE])
				result_of = ctl[`CTL_INVERT];
			else
				result_of = raw ^ ctl[`CTL_INVERT];
		end
	endfunction

	// Stored form of a control write: result bit is read-only
	function [7:0] ctl_store;
		input [7:0] wdata;
		begin
			ctl_store = {wdata[7], 1'b0, wdata[5:0]};
		end
	endfunction

	// Read view of a control register with the live result in bit 6
	function [31:0] ctl_view;
		input [7:0] ctl;
		input res;
		begin
			ctl_view = {24'h000000, ctl[7], res, ctl[5:0]};
		end
	endfunction

	// One field bit from both control registers, comparator 1 low
	function [1:0] pair_bit;
		input [7:0] hi;
		input [7:0] lo;
		input [31:0] pos;
		begin
			pair_bit = {hi[pos], lo[pos]};
		end
	endfunction

	// Address compare against one register offset
	function addr_is;
		input [11:0] a;
		input [11:0] ofs;
		begin
			addr_is = (a == ofs);
		end
	endfunction

	wire [1:0] live = {result_of(ctl2_q, raw_compare[1]), result_of(ctl1_q, raw_compare[0])};
	wire [1:0] mismatch = first_q ^ second_q;
	wire hit1 = addr_is(paddr, `CMP1_CTRL_OFS);
	wire hit2 = addr_is(paddr, `CMP2_CTRL_OFS);
	wire hit_sh = addr_is(paddr, `SHARED_CTRL_OFS);
	wire hit_flag = addr_is(paddr, `FLAG_OFS);
	wire hit_ie = addr_is(paddr, `IRQ_EN_OFS);
	wire hit_pin = addr_is(paddr, `PIN_CFG_OFS);
	wire mapped = hit1 | hit2 | hit_sh | hit_flag | hit_ie | hit_pin;

	// ----------------------------------------
	// APB access: control register accesses wait for Q3
	// ----------------------------------------
	// Slave answers in the Q3 cycle for control registers so the mismatch
	// reload comes first and the write lands one phase later.
	wire ctl_hit = hit1 | hit2;
	wire ready_now = psel & penable & ~pready & (~ctl_hit | q3);
	// Writes land only at the edge where pready is sampled high
	wire acc = psel & penable & pready;
	wire wr_acc = acc & pwrite;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= ready_now;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			// Unmapped addresses answer with an error; writes are dropped
			pslverr <= ready_now & ~mapped;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (clk_en) begin
			if (ready_now & ~pwrite) begin
				case (paddr)
				`CMP1_CTRL_OFS: prdata <= ctl_view(ctl1_q, live[0]);
				`CMP2_CTRL_OFS: prdata <= ctl_view(ctl2_q, live[1]);
				`SHARED_CTRL_OFS: prdata <= {24'h000000, sync_q[0], sync_q[1], shared_q[5:0]};
				`FLAG_OFS: prdata <= {30'h00000000, cmp_irq_flag};
				`IRQ_EN_OFS: prdata <= {28'h0000000, irq_en_q};
				`PIN_CFG_OFS: prdata <= {30'h00000000, pin_dir_q};
				default: prdata <= 32'h00000000;
				endcase
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_q <= `CTL_RESET;
		end else if (clk_en & wr_acc & hit1) begin
			ctl1_q <= ctl_store(pwdata[7:0]);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl2_q <= `CTL_RESET;
		end else if (clk_en & wr_acc & hit2) begin
			ctl2_q <= ctl_store(pwdata[7:0]);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_q <= `SH_RESET;
		end else if (clk_en & wr_acc & hit_sh) begin
			shared_q <= {2'h0, pwdata[5:0]};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= 4'h0;
		end else if (clk_en & wr_acc & hit_ie) begin
			irq_en_q <= pwdata[3:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_dir_q <= 2'h3;
		end else if (clk_en & wr_acc & hit_pin) begin
			pin_dir_q <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// Mismatch latches
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 2'h0;
			second_q <= 2'h0;
		end else if (clk_en) begin
			// Mirror copy reads never disturb the mismatch latches
			if (q1) begin
				sync_q <= live;
				second_q <= live;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_q <= 2'h0;
		end else if (clk_en) begin
			// Each control register access reloads its own comparator's bit at Q3, before its write lands
			if (ready_now & hit1) begin
				first_q[0] <= live[0];
			end
			if (ready_now & hit2) begin
				first_q[1] <= live[1];
			end
		end
	end

	// ----------------------------------------
	// Interrupt flags: set on mismatch rising edge, set wins
	// ----------------------------------------
	wire flag_wr = wr_acc & hit_flag;
	wire [1:0] rise = mismatch & ~mis_prev_q;
	wire [1:0] flag_d = (flag_wr ? pwdata[1:0] : cmp_irq_flag) | rise;
	wire [1:0] ie_cmp = {irq_en_q[`IE_CMP2], irq_en_q[`IE_CMP1]};
	wire wake_d = |(flag_d & ie_cmp) & irq_en_q[`IE_PERIPH];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mis_prev_q <= 2'h0;
		end else if (clk_en) begin
			// A change right as the first latch reloads can go unseen
			mis_prev_q <= mismatch;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_irq_flag <= 2'h0;
		end else if (clk_en) begin
			// A mismatch rise beats a same-cycle software clear
			cmp_irq_flag <= flag_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_request <= 1'b0;
		end else if (clk_en) begin
			wake_request <= wake_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else if (clk_en) begin
			irq_request <= wake_d & irq_en_q[`IE_GLOBAL];
		end
	end

	// ----------------------------------------
	// Analog controls and pin drive
	// ----------------------------------------
	wire [1:0] drive = pair_bit(ctl2_q, ctl1_q, `CTL_PIN_DRIVE);
	wire [1:0] ena = pair_bit(ctl2_q, ctl1_q, `CTL_ENABLE);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_pin_out <= 2'h0;
		end else if (clk_en) begin
			// Pin path uses the live result; only the internal copy is latched
			cmp_pin_out <= drive & live | ~drive & port_latch;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_pin_oe <= 2'h0;
		end else if (clk_en) begin
			// Direction bit set means input: the pin stays released
			cmp_pin_oe <= drive & ~pin_dir_q & ena;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_power_on <= 2'h0;
		end else if (clk_en) begin
			// Cleared enable parks the comparator at its lowest current
			cmp_power_on <= ena;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_fast_mode <= 2'h3;
		end else if (clk_en) begin
			// Speed bit resets high: fast mode
			cmp_fast_mode <= pair_bit(ctl2_q, ctl1_q, `CTL_SPEED);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			neg_input_select <= 4'h0;
		end else if (clk_en) begin
			neg_input_select <= {ctl2_q[1:0], ctl1_q[1:0]};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_ref_select <= 2'h0;
		end else if (clk_en) begin
			pos_ref_select <= pair_bit(ctl2_q, ctl1_q, `CTL_REF_SEL);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vref_source_select <= 2'h0;
		end else if (clk_en) begin
			vref_source_select <= {shared_q[`SH_VSRC2], shared_q[`SH_VSRC1]};
		end
	end

endmodule

// ---- tb/cmp_ctrl_monitor.sv ----
// Assertion checker for the comparator control block
`timescale 1ns/100ps
module cmp_ctrl_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [1:0] cmp_pin_oe,
	input wire [1:0] cmp_power_on,
	input wire [1:0] cmp_irq_flag,
	input wire irq_request,
	input wire wake_request
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Bus steps
	// ----------------------------------------
	sequence s_access;
		psel && $rose(penable);
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	AST_ANSWER: assert property (s_access |-> ##[1:5] s_answer)
		else $error("access not answered in time");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("error without answer");
	AST_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	// Enable output lags its source by one register stage
	AST_OE1: assert property (cmp_pin_oe[0] |-> cmp_power_on[0] || $past(cmp_power_on[0]))
		else $error("pin 1 driven while off");
	AST_OE2: assert property (cmp_pin_oe[1] |-> cmp_power_on[1] || $past(cmp_power_on[1]))
		else $error("pin 2 driven while off");
	AST_IRQ: assert property (irq_request |-> |(cmp_irq_flag | $past(cmp_irq_flag)))
		else $error("request without flag");
	AST_WAKE: assert property (wake_request |-> |(cmp_irq_flag | $past(cmp_irq_flag)))
		else $error("wake without flag");
	AST_FLAG: assert property ($fell(cmp_irq_flag[0]) |-> $past(psel) || $past(psel, 2))
		else $error("flag dropped without access");
endmodule

bind cmp_ctrl cmp_ctrl_monitor i_mon (.pclk, .presetn, .psel, .penable, .prdata, .pready,
	.pslverr, .cmp_pin_oe, .cmp_power_on, .cmp_irq_flag, .irq_request, .wake_request);

// ---- tb/test_cmp_ctrl.sv ----
// Self-checking testbench for the comparator control block
`timescale 1ns/100ps
`include "cmp_ctrl_map.vh"
module test_cmp_ctrl;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, errv = 0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rdv;
	reg [1:0] raw_compare = 2'h0, port_latch = 2'h0;
	wire [31:0] prdata;
	wire pready, pslverr, irq_request, wake_request;
	wire [1:0] cmp_pin_out, cmp_pin_oe, cmp_power_on, cmp_fast_mode, pos_ref_select;
	wire [1:0] vref_source_select, cmp_irq_flag;
	wire [3:0] neg_input_select;
	integer errors = 0, num_checks = 0, cyc = 0;
	always #25 pclk = ~pclk;
	cmp_ctrl i_cmp_ctrl (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .raw_compare, .port_latch, .cmp_pin_out,
		.cmp_pin_oe, .cmp_power_on, .cmp_fast_mode, .neg_input_select, .pos_ref_select,
		.vref_source_select, .cmp_irq_flag, .irq_request, .wake_request);
	// ----------------------------------------
	// Check, bus, compare-input and finish tasks
	// ----------------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
		begin
			n = 0;
			@(posedge pclk);
			psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'h0;
			@(posedge pclk);
			penable <= 1'h1;
			// Values read right after an edge are those that edge sampled
			@(posedge pclk);
			while (pready !== 1'h1 && n < 20) begin
				@(posedge pclk);
				n = n + 1;
			end
			rdv = prdata;
			errv = pslverr;
			if (n >= 20) errors = errors + 1;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task rd(input [11:0] a, input [31:0] e);
		begin
			apb(1'h0, a, 32'h0);
			chk(rdv, e);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			apb(1'h1, a, d);
			// Registered outputs follow the write by one edge
			repeat (2) @(negedge pclk);
		end
	endtask
	task cmp(input [1:0] v);
		begin
			@(posedge pclk);
			raw_compare <= v;
			repeat (10) @(posedge pclk);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			errors = errors + 1;
			finish_test;
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		rd(`CMP1_CTRL_OFS, 32'h08);
		chk(32'(cmp_fast_mode), 32'h3);
		rd(12'h018, 32'h0);
		chk(32'(errv), 32'h1);
		wr(`CMP1_CTRL_OFS, 32'h10);
		rd(`CMP1_CTRL_OFS, 32'h50);
		wr(`CMP1_CTRL_OFS, 32'h87);
		chk(32'(cmp_power_on), 32'h1);
		chk(32'(neg_input_select), 32'h3);
		chk(32'(pos_ref_select), 32'h1);
		chk(32'(cmp_fast_mode), 32'h2);
		rd(`CMP1_CTRL_OFS, 32'h87);
		wr(`FLAG_OFS, 32'h0);
		cmp(2'h1);
		rd(`FLAG_OFS, 32'h1);
		wr(`FLAG_OFS, 32'h0);
		cmp(2'h0);
		rd(`FLAG_OFS, 32'h0);
		cmp(2'h1);
		rd(`FLAG_OFS, 32'h1);
		rd(`CMP1_CTRL_OFS, 32'hC7);
		wr(`FLAG_OFS, 32'h0);
		cmp(2'h0);
		rd(`FLAG_OFS, 32'h1);
		wr(`CMP1_CTRL_OFS, 32'h97);
		rd(`CMP1_CTRL_OFS, 32'hD7);
		wr(`FLAG_OFS, 32'h3);
		rd(`FLAG_OFS, 32'h3);
		wr(`IRQ_EN_OFS, 32'h7);
		chk(32'(irq_request), 32'h0);
		chk(32'(wake_request), 32'h1);
		wr(`IRQ_EN_OFS, 32'hF);
		chk(32'(irq_request), 32'h1);
		@(posedge pclk);
		port_latch <= 2'h3;
		wr(`PIN_CFG_OFS, 32'h0);
		wr(`CMP1_CTRL_OFS, 32'hB7);
		chk(32'(cmp_pin_oe), 32'h1);
		chk(32'(cmp_pin_out), 32'h3);
		wr(`CMP1_CTRL_OFS, 32'h30);
		chk(32'(cmp_pin_oe), 32'h0);
		chk(32'(cmp_pin_out), 32'h3);
		wr(`SHARED_CTRL_OFS, 32'h30);
		chk(32'(vref_source_select), 32'h3);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(`CMP1_CTRL_OFS, 32'h08);
		rd(`FLAG_OFS, 32'h0);
		finish_test;
	end
endmodule
